/* include/fps_pkg.sv */
package fps_pkg;

  // Core clock and the link rates it has to serve.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BPS_MIN = 4800;
  localparam int unsigned BPS_MAX = 76800;
  localparam int unsigned BPS_BOOT = 9600;
  localparam int unsigned SCK_MIN_HZ = 200_000;
  localparam int unsigned SCK_MAX_HZ = 1_000_000;
  // Shortest and longest serial clock half periods in core cycles.
  localparam int unsigned SCK_HALF_MIN_CYC = CLK_HZ / (2 * SCK_MAX_HZ);
  localparam int unsigned SCK_HALF_MAX_CYC = CLK_HZ / (2 * SCK_MIN_HZ);
  // Bit periods of the slowest and fastest rates; faster rates divide the slowest by powers of two.
  localparam int unsigned BIT_CYC_MIN_RATE = CLK_HZ / BPS_MIN;
  localparam int unsigned BIT_CYC_MAX_RATE = CLK_HZ / BPS_MAX;
  localparam logic [3:0] BAUD_SEL_BOOT = 4'h1;
  localparam logic [3:0] BAUD_SEL_MAX = 4'h4;

  // Program-voltage pulse counts that pick the link.
  localparam logic [4:0] PULSE_MAX = 5'h10;
  localparam logic [4:0] PULSE_SYNC = 5'h00;
  localparam logic [4:0] PULSE_SYNC_HS = 5'h03;
  localparam logic [4:0] PULSE_ASYNC = 5'h08;

  // Cycles the strap waits so that the synchroniser holds real pin levels.
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [1:0] {LINK_SYNC, LINK_SYNC_HS, LINK_ASYNC, LINK_BAD} fps_link_e;
  typedef enum logic [1:0] {FL_ERASE, FL_BLANK, FL_WRITE, FL_VERIFY} fps_flop_e;

  // Programmer command codes and the two answers.
  localparam logic [7:0] CMD_RESET = 8'h01;
  localparam logic [7:0] CMD_VERIFY = 8'h13;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLANK = 8'h32;
  localparam logic [7:0] CMD_HSWRITE = 8'h40;
  localparam logic [7:0] CMD_SUCWRITE = 8'h44;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_OSC = 8'h90;
  localparam logic [7:0] CMD_ERASE_TIME = 8'h95;
  localparam logic [7:0] CMD_WRITE_TIME = 8'h96;
  localparam logic [7:0] CMD_BAUD = 8'h9a;
  localparam logic [7:0] CMD_SIGNATURE = 8'hc0;
  localparam logic [7:0] RSP_ACK = 8'h06;
  localparam logic [7:0] RSP_NAK = 8'h15;
  // Signature value is arbitrary.
  localparam logic [7:0] SIG_CODE = 8'h5a;

  // Argument byte counts: address of three bytes plus count, or one byte.
  localparam logic [2:0] ARGS_HSWRITE = 3'h4;
  localparam logic [2:0] ARGS_ONE = 3'h1;

  // Status byte field positions.
  localparam int unsigned ST_FAIL = 0;
  localparam int unsigned ST_OVR = 1;
  localparam int unsigned ST_CAL = 2;

  // Work RAM window held back for programming mode; nothing here touches it.
  localparam logic [31:0] WORK_RAM_LO = 32'h03ffe800;
  localparam logic [31:0] WORK_RAM_HI = 32'h03ffefff;

  typedef struct packed {
    fps_flop_e op;
    logic [23:0] addr;
    logic [7:0] data;
  } fps_flreq_s;

  typedef struct packed {
    logic [7:0] osc;
    logic [7:0] erase_time;
    logic [7:0] write_time;
  } fps_cfg_s;

endpackage

/* src/fps_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of pins; the first stage feeds only the second.
module fps_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic [W-1:0] d_i, // Asynchronous inputs.
  output logic [W-1:0] q_o // Synchronised outputs.
);
  logic [W-1:0] meta_q;

  // Both stages reset to zero so the pins read idle-low until sampled.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // fps_sync2

`default_nettype wire

/* src/fps_buf2.sv */
`timescale 1ns/1ps
`default_nettype none

// Small FIFO with valid/ready on both sides; default two entries.
module fps_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i, // Core clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Room for a word.
  input wire logic [W-1:0] in_data_i, // Word in.
  output logic out_valid_o, // Word held.
  input wire logic out_ready_i, // Reader takes the word.
  output logic [W-1:0] out_data_o // Oldest word.
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, rd_q;
  logic [CW-1:0] cnt_q;
  logic push, pop;

  assign in_ready_o = (cnt_q != CNT_FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, so any depth works, not only powers of two.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PTR_LAST) ? '0 : PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == PTR_LAST) ? '0 : PW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule // fps_buf2

`default_nettype wire

/* src/fps_top.sv */
`timescale 1ns/1ps
`default_nettype none

module fps_top
  import fps_pkg::*;
#(
  parameter int NPORT = 8,
  parameter logic [15:0] BIT_CYC_4800 = 16'(fps_pkg::CLK_HZ / fps_pkg::BPS_MIN)
) (
  input wire logic MCLK_I, // Core clock, 40 MHz.
  input wire logic ARST_N_I, // Reset pin, active low.
  input wire logic VPP_HI_I, // Program voltage present.
  input wire logic SYNC_SERIAL_CLOCK_I, // Clocked link clock from programmer.
  input wire logic SYNC_SERIAL_IN_I, // Clocked link data in.
  input wire logic ASYNC_RX_LINE_I, // Async link data in.
  input wire logic FL_DONE_I, // Flash engine finished a request.
  input wire logic FL_OK_I, // Flash request result good.
  output logic PROG_MODE_O, // Programming mode active.
  output fps_pkg::fps_link_e LINK_MODE_O, // Selected link.
  output logic LINK_LOCKED_O, // Link choice frozen.
  output logic SYNC_SERIAL_OUT_O, // Clocked link data out.
  output logic SYNC_SERIAL_OUT_OE_O, // Drive enable for data out.
  output logic HANDSHAKE_LINE_O, // High when ready for a byte.
  output logic ASYNC_TX_LINE_O, // Async link data out.
  output logic FL_REQ_O, // Flash request pulse.
  output fps_pkg::fps_flreq_s FL_CMD_O, // Flash request contents.
  output fps_pkg::fps_cfg_s CFG_O, // Stored timing settings.
  output logic [NPORT-1:0] PORT_OE_O // Other port drive enables.
);
  import fps_pkg::*;

  typedef enum {ARX_IDLE, ARX_START, ARX_DATA, ARX_STOP} fps_arx_e;
  typedef enum {CI_IDLE, CI_ARG, CI_DATA, CI_WAIT, CI_RESP} fps_ci_e;

  logic vpp_s, sck_s, sin_s, rx_s;
  logic vpp_d_q, sck_d_q, rx_d_q;
  logic [1:0] strap_q;
  logic prog_q, locked_q;
  logic [4:0] pulses_q;
  fps_link_e link_q, link_now;
  logic sck_rise, sck_fall, rx_fall, act;
  logic [7:0] resp_q;
  logic resp_v_q, resp_take, resp_load;
  logic rx_push, rx_ready, byte_v, byte_take, ovr_q;
  logic [7:0] rx_byte, byte_d;
  logic [7:0] srx_sh_q, stx_sh_q;
  logic [2:0] sbit_q;
  logic srx_push, arx_push;
  fps_arx_e arx_q;
  logic [15:0] arx_cnt_q, period_q;
  logic [7:0] arx_sh_q;
  logic [2:0] arx_bit_q;
  logic cal_q, atx_busy_q, baud_pend_q, baud_go_q;
  logic [9:0] atx_sh_q;
  logic [3:0] atx_bit_q, baud_sel_q;
  logic [15:0] atx_cnt_q;
  fps_ci_e ci_q;
  logic [7:0] cmd_q, r1_q, r2_q;
  logic r2v_q, fail_q, fl_req_q;
  logic [23:0] arg_q, waddr_q, vaddr_q;
  logic [31:0] arg_nv;
  logic [2:0] argn_q;
  logic [8:0] len_q;
  fps_flreq_s fl_cmd_q;
  fps_cfg_s cfg_q;

  fps_sync2 #(.W(4)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(ARST_N_I),
    .d_i({VPP_HI_I, SYNC_SERIAL_CLOCK_I, SYNC_SERIAL_IN_I, ASYNC_RX_LINE_I}),
    .q_o({vpp_s, sck_s, sin_s, rx_s})
  );

  // Edges come from synchronised levels only; the link clock is just another pin.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      vpp_d_q <= 1'b0;
      sck_d_q <= 1'b0;
      rx_d_q <= 1'b1;
    end else begin
      vpp_d_q <= vpp_s;
      sck_d_q <= sck_s;
      rx_d_q <= rx_s;
    end
  end
  assign sck_rise = sck_s && !sck_d_q;
  assign sck_fall = !sck_s && sck_d_q;
  assign rx_fall = !rx_s && rx_d_q;

  // The strap is caught after release, once the synchroniser shows the pin; only
  // the reset pin itself can leave the mode again.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      strap_q <= '0;
      prog_q <= 1'b0;
    end else if (strap_q != STRAP_WAIT) begin
      strap_q <= 2'(strap_q + 1'b1);
      if (2'(strap_q + 1'b1) == STRAP_WAIT) begin
        prog_q <= vpp_s;
      end
    end
  end

  // Pulse count saturates so a runaway programmer cannot wrap back to a legal code.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pulses_q <= PULSE_SYNC;
      locked_q <= 1'b0;
      link_q <= LINK_SYNC;
    end else if (prog_q && !locked_q) begin
      if (vpp_s && !vpp_d_q && pulses_q != PULSE_MAX) begin
        pulses_q <= 5'(pulses_q + 1'b1);
      end
      if (sck_rise || sck_fall || rx_fall) begin
        locked_q <= 1'b1;
        link_q <= link_now;
      end
    end
  end

  // Decode is live until lock so the very first link edge is already served.
  always_comb begin
    link_now = link_q;
    if (!locked_q) begin
      unique case (pulses_q)
        PULSE_SYNC: link_now = LINK_SYNC;
        PULSE_SYNC_HS: link_now = LINK_SYNC_HS;
        PULSE_ASYNC: link_now = LINK_ASYNC;
        default: link_now = LINK_BAD;
      endcase
    end
  end
  assign act = prog_q && (link_now != LINK_BAD);

  // Clocked slave: sample on rise, shift out on fall, MSB first.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      srx_sh_q <= '0;
      stx_sh_q <= 8'hff;
      sbit_q <= '0;
    end else if (act && link_now != LINK_ASYNC) begin
      if (sck_rise) begin
        srx_sh_q <= {srx_sh_q[6:0], sin_s};
        sbit_q <= 3'(sbit_q + 1'b1);
      end else if (sck_fall) begin
        if (sbit_q == '0) begin
          stx_sh_q <= resp_v_q ? resp_q : 8'hff;
        end else begin
          stx_sh_q <= {stx_sh_q[6:0], 1'b1};
        end
      end
    end
  end
  assign srx_push = act && link_now != LINK_ASYNC && sck_rise && sbit_q == 3'h7;

  // Async receiver; the first start bit, that of the reset command, sets the bit time.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      arx_q <= ARX_IDLE;
      arx_cnt_q <= '0;
      arx_sh_q <= '0;
      arx_bit_q <= '0;
      cal_q <= 1'b0;
      period_q <= BIT_CYC_4800 >> BAUD_SEL_BOOT;
    end else begin
      if (baud_pend_q && !atx_busy_q && !resp_v_q) begin
        period_q <= BIT_CYC_4800 >> baud_sel_q;
      end
      unique case (arx_q)
        ARX_IDLE: begin
          if (act && link_now == LINK_ASYNC && rx_fall) begin
            arx_q <= ARX_START;
            arx_cnt_q <= cal_q ? (period_q >> 1) : 16'h0000;
          end
        end
        ARX_START: begin
          if (!cal_q) begin
            arx_cnt_q <= 16'(arx_cnt_q + 1'b1);
            if (rx_s) begin
              cal_q <= 1'b1;
              period_q <= 16'(arx_cnt_q + 1'b1);
              arx_cnt_q <= 16'(arx_cnt_q + 1'b1) >> 1;
              arx_bit_q <= '0;
              arx_q <= ARX_DATA;
            end
          end else if (arx_cnt_q == '0) begin
            arx_cnt_q <= period_q;
            arx_bit_q <= '0;
            arx_q <= rx_s ? ARX_IDLE : ARX_DATA;
          end else begin
            arx_cnt_q <= 16'(arx_cnt_q - 1'b1);
          end
        end
        ARX_DATA: begin
          if (arx_cnt_q == '0) begin
            arx_sh_q <= {rx_s, arx_sh_q[7:1]};
            arx_bit_q <= 3'(arx_bit_q + 1'b1);
            arx_cnt_q <= period_q;
            if (arx_bit_q == 3'h7) begin
              arx_q <= ARX_STOP;
            end
          end else begin
            arx_cnt_q <= 16'(arx_cnt_q - 1'b1);
          end
        end
        ARX_STOP: begin
          if (arx_cnt_q == '0) begin
            arx_q <= ARX_IDLE;
          end else begin
            arx_cnt_q <= 16'(arx_cnt_q - 1'b1);
          end
        end
      endcase
    end
  end
  // A frame with a low stop bit is dropped as a framing error.
  assign arx_push = arx_q == ARX_STOP && arx_cnt_q == '0 && rx_s;

  // Async transmitter, LSB first, start and stop framed.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      atx_busy_q <= 1'b0;
      atx_sh_q <= '1;
      atx_bit_q <= '0;
      atx_cnt_q <= '0;
    end else if (!atx_busy_q) begin
      if (resp_v_q && act && link_now == LINK_ASYNC) begin
        atx_busy_q <= 1'b1;
        atx_sh_q <= {1'b1, resp_q, 1'b0};
        atx_bit_q <= '0;
        atx_cnt_q <= period_q;
      end
    end else if (atx_cnt_q == '0) begin
      atx_sh_q <= {1'b1, atx_sh_q[9:1]};
      atx_cnt_q <= period_q;
      atx_bit_q <= 4'(atx_bit_q + 1'b1);
      if (atx_bit_q == 4'h9) begin
        atx_busy_q <= 1'b0;
      end
    end else begin
      atx_cnt_q <= 16'(atx_cnt_q - 1'b1);
    end
  end

  // A pending rate change waits until the ACK that announced it has left.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      baud_pend_q <= 1'b0;
    end else if (baud_go_q) begin
      baud_pend_q <= 1'b1;
    end else if (!atx_busy_q && !resp_v_q) begin
      baud_pend_q <= 1'b0;
    end
  end

  assign resp_take = resp_v_q && act && ((link_now == LINK_ASYNC) ? !atx_busy_q :
                     (sck_fall && sbit_q == '0));
  assign resp_load = ci_q == CI_RESP && !resp_v_q;

  // Single response slot between the interpreter and whichever link is live.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      resp_v_q <= 1'b0;
      resp_q <= RSP_NAK;
    end else if (resp_load) begin
      resp_v_q <= 1'b1;
      resp_q <= r1_q;
    end else if (resp_take) begin
      resp_v_q <= 1'b0;
    end
  end

  assign rx_push = srx_push || arx_push;
  assign rx_byte = srx_push ? {srx_sh_q[6:0], sin_s} : arx_sh_q;

  fps_buf2 #(.W(8), .DEPTH(2)) u_rxbuf (
    .clk_i(MCLK_I),
    .rst_n_i(ARST_N_I),
    .in_valid_i(rx_push),
    .in_ready_o(rx_ready),
    .in_data_i(rx_byte),
    .out_valid_o(byte_v),
    .out_ready_i(byte_take),
    .out_data_o(byte_d)
  );

  // Overrun sticks until a reset command; a new overrun in that cycle still wins.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ovr_q <= 1'b0;
    end else if (rx_push && !rx_ready) begin
      ovr_q <= 1'b1;
    end else if (byte_take && ci_q == CI_IDLE && byte_d == CMD_RESET) begin
      ovr_q <= 1'b0;
    end
  end

  assign byte_take = byte_v && (ci_q == CI_IDLE || ci_q == CI_ARG || ci_q == CI_DATA);
  assign arg_nv = {arg_q, byte_d};

  // Command interpreter: one command at a time, every one answered.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ci_q <= CI_IDLE;
      cmd_q <= '0;
      r1_q <= RSP_NAK;
      r2_q <= '0;
      r2v_q <= 1'b0;
      fail_q <= 1'b0;
      arg_q <= '0;
      argn_q <= '0;
      len_q <= '0;
      waddr_q <= '0;
      vaddr_q <= '0;
      fl_req_q <= 1'b0;
      fl_cmd_q <= '0;
      cfg_q <= '0;
      baud_sel_q <= BAUD_SEL_BOOT;
      baud_go_q <= 1'b0;
    end else begin
      fl_req_q <= 1'b0;
      baud_go_q <= 1'b0;
      unique case (ci_q)
        CI_IDLE: begin
          if (byte_take) begin
            cmd_q <= byte_d;
            r1_q <= RSP_ACK;
            r2v_q <= 1'b0;
            argn_q <= ARGS_ONE;
            ci_q <= CI_ARG;
            unique case (byte_d)
              CMD_RESET: begin
                fail_q <= 1'b0;
                vaddr_q <= '0;
                ci_q <= CI_RESP;
              end
              CMD_ERASE, CMD_BLANK: begin
                fl_cmd_q.op <= (byte_d == CMD_ERASE) ? FL_ERASE : FL_BLANK;
                fl_req_q <= 1'b1;
                ci_q <= CI_WAIT;
              end
              CMD_HSWRITE: argn_q <= ARGS_HSWRITE;
              CMD_SUCWRITE, CMD_VERIFY, CMD_OSC, CMD_ERASE_TIME, CMD_WRITE_TIME,
              CMD_BAUD: argn_q <= ARGS_ONE;
              CMD_STATUS: begin
                r2_q <= {5'h00, cal_q, ovr_q, fail_q};
                r2v_q <= 1'b1;
                ci_q <= CI_RESP;
              end
              CMD_SIGNATURE: begin
                r2_q <= SIG_CODE;
                r2v_q <= 1'b1;
                ci_q <= CI_RESP;
              end
              default: begin
                r1_q <= RSP_NAK;
                ci_q <= CI_RESP;
              end
            endcase
          end
        end
        CI_ARG: begin
          if (byte_take) begin
            arg_q <= arg_nv[23:0];
            argn_q <= 3'(argn_q - 1'b1);
            if (argn_q == ARGS_ONE) begin
              len_q <= {arg_nv[7:0] == 8'h00, arg_nv[7:0]};
              fail_q <= 1'b0;
              ci_q <= CI_DATA;
              unique case (cmd_q)
                CMD_HSWRITE: waddr_q <= arg_nv[31:8];
                CMD_OSC: begin
                  cfg_q.osc <= arg_nv[7:0];
                  ci_q <= CI_RESP;
                end
                CMD_ERASE_TIME: begin
                  cfg_q.erase_time <= arg_nv[7:0];
                  ci_q <= CI_RESP;
                end
                CMD_WRITE_TIME: begin
                  cfg_q.write_time <= arg_nv[7:0];
                  ci_q <= CI_RESP;
                end
                CMD_BAUD: begin
                  if (arg_nv[7:0] <= {4'h0, BAUD_SEL_MAX}) begin
                    baud_sel_q <= arg_nv[3:0];
                    baud_go_q <= 1'b1;
                  end else begin
                    r1_q <= RSP_NAK;
                  end
                  ci_q <= CI_RESP;
                end
                default: ci_q <= CI_DATA;
              endcase
            end
          end
        end
        CI_DATA: begin
          if (byte_take) begin
            fl_cmd_q.op <= (cmd_q == CMD_VERIFY) ? FL_VERIFY : FL_WRITE;
            fl_cmd_q.addr <= (cmd_q == CMD_VERIFY) ? vaddr_q : waddr_q;
            fl_cmd_q.data <= byte_d;
            fl_req_q <= 1'b1;
            ci_q <= CI_WAIT;
          end
        end
        CI_WAIT: begin
          if (FL_DONE_I) begin
            if (cmd_q == CMD_ERASE || cmd_q == CMD_BLANK) begin
              r1_q <= FL_OK_I ? RSP_ACK : RSP_NAK;
              fail_q <= !FL_OK_I;
              ci_q <= CI_RESP;
            end else begin
              if (cmd_q == CMD_VERIFY) begin
                vaddr_q <= 24'(vaddr_q + 1'b1);
              end else begin
                waddr_q <= 24'(waddr_q + 1'b1);
              end
              fail_q <= fail_q || !FL_OK_I;
              len_q <= 9'(len_q - 1'b1);
              r1_q <= (fail_q || !FL_OK_I) ? RSP_NAK : RSP_ACK;
              ci_q <= (len_q == 9'h001) ? CI_RESP : CI_DATA;
            end
          end
        end
        CI_RESP: begin
          if (!resp_v_q) begin
            r1_q <= r2_q;
            r2v_q <= 1'b0;
            ci_q <= r2v_q ? CI_RESP : CI_IDLE;
          end
        end
      endcase
    end
  end

  // Pin outputs are registered; other ports never drive in this mode.
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SYNC_SERIAL_OUT_OE_O <= 1'b0;
      HANDSHAKE_LINE_O <= 1'b0;
      ASYNC_TX_LINE_O <= 1'b1;
      PORT_OE_O <= '0;
    end else begin
      SYNC_SERIAL_OUT_OE_O <= act && link_now != LINK_ASYNC;
      HANDSHAKE_LINE_O <= act && link_now == LINK_SYNC_HS && rx_ready;
      ASYNC_TX_LINE_O <= atx_busy_q ? atx_sh_q[0] : 1'b1;
      PORT_OE_O <= '0;
    end
  end

  assign SYNC_SERIAL_OUT_O = stx_sh_q[7];
  assign PROG_MODE_O = prog_q;
  assign LINK_MODE_O = link_q;
  assign LINK_LOCKED_O = locked_q;
  assign FL_REQ_O = fl_req_q;
  assign FL_CMD_O = fl_cmd_q;
  assign CFG_O = cfg_q;
endmodule // fps_top

`default_nettype wire

/* bench/fps_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port checker: once mode or lock is set it must hold; pin states must suit the link choice.
module fps_checker
  import fps_pkg::*;
#(parameter int NPORT = 8) (
  input wire logic MCLK_I, // Clock.
  input wire logic ARST_N_I, // Reset.
  input wire logic PROG_MODE_O, // Mode.
  input wire fps_pkg::fps_link_e LINK_MODE_O, // Link.
  input wire logic LINK_LOCKED_O, // Lock.
  input wire logic SYNC_SERIAL_OUT_OE_O, // Out enable.
  input wire logic HANDSHAKE_LINE_O, // Ready line.
  input wire logic ASYNC_TX_LINE_O, // Async out.
  input wire logic FL_REQ_O, // Flash request.
  input wire logic [NPORT-1:0] PORT_OE_O // Port enables.
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  AST_PORT_HIZ: assert property (PORT_OE_O == '0)
    else $error("port enable raised");
  AST_PROG_HOLD: assert property (PROG_MODE_O |=> PROG_MODE_O)
    else $error("mode dropped");
  AST_LOCK_HOLD: assert property (LINK_LOCKED_O |=>
    LINK_LOCKED_O && $stable(LINK_MODE_O))
    else $error("link choice moved");
  AST_LOCK_PROG: assert property (LINK_LOCKED_O |-> PROG_MODE_O)
    else $error("lock outside mode");
  AST_REQ_PULSE: assert property (FL_REQ_O |=> !FL_REQ_O)
    else $error("request too long");
  AST_HS_ONLY: assert property (HANDSHAKE_LINE_O |->
    PROG_MODE_O && (!LINK_LOCKED_O || LINK_MODE_O == LINK_SYNC_HS))
    else $error("ready line wrong mode");
  AST_OE_SYNC: assert property (SYNC_SERIAL_OUT_OE_O |->
    PROG_MODE_O && LINK_MODE_O inside {LINK_SYNC, LINK_SYNC_HS})
    else $error("data out driven wrongly");
  AST_TX_IDLE: assert property (!(LINK_LOCKED_O && LINK_MODE_O == LINK_ASYNC) |->
    ASYNC_TX_LINE_O)
    else $error("async out not idle");
  AST_BAD_QUIET: assert property (LINK_MODE_O == LINK_BAD |->
    !SYNC_SERIAL_OUT_OE_O && !FL_REQ_O)
    else $error("prohibited mode active");
  // The async, handshake and prohibited link choices are each reached.
  cover property (LINK_LOCKED_O && LINK_MODE_O == LINK_ASYNC);
  cover property (LINK_LOCKED_O && LINK_MODE_O == LINK_SYNC_HS);
  cover property (LINK_LOCKED_O && LINK_MODE_O == LINK_BAD);
endmodule // fps_checker
bind fps_top fps_checker #(.NPORT(NPORT)) u_fps_checker (.MCLK_I, .ARST_N_I, .PROG_MODE_O,
  .LINK_MODE_O, .LINK_LOCKED_O, .SYNC_SERIAL_OUT_OE_O, .HANDSHAKE_LINE_O, .ASYNC_TX_LINE_O,
  .FL_REQ_O, .PORT_OE_O);
`default_nettype wire

/* bench/fps_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Programmer model; every change lands on a falling core clock edge.
module fps_prog_model (
  input wire logic clk_i, // Core clock.
  input wire logic so_i, // Clocked data from device.
  input wire logic tx_i, // Async data from device.
  output logic rst_n_o, // Reset pin.
  output logic vpp_o, // Program voltage.
  output logic sck_o, // Link clock, idles high.
  output logic si_o, // Clocked data to device.
  output logic rx_o // Async data to device.
);
  initial begin
    rst_n_o = 0; vpp_o = 0; sck_o = 1; si_o = 1; rx_o = 1;
  end
  // Only this model drives reset; voltage goes up before reset leaves.
  task automatic enter();
    rst_n_o = 0; vpp_o = 1;
    repeat (2) @(negedge clk_i);
    rst_n_o = 1;
    repeat (8) @(negedge clk_i);
  endtask
  // Pulses of four cycles low and high, all after the strap has been caught.
  task automatic pulses(input int n);
    repeat (n) begin
      vpp_o = 0; repeat (4) @(negedge clk_i);
      vpp_o = 1; repeat (4) @(negedge clk_i);
    end
    repeat (6) @(negedge clk_i);
  endtask
  // One byte each way at 800 kHz, MSB first, read back on the rise.
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 0; si_o = b[i];
      repeat (25) @(negedge clk_i);
      r[i] = so_i; sck_o = 1;
      repeat (25) @(negedge clk_i);
    end
  endtask
  // Async frame, LSB first, bt core cycles a bit.
  task automatic send(input logic [7:0] b, input int bt);
    rx_o = 0; repeat (bt) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_o = b[i]; repeat (bt) @(negedge clk_i);
    end
    rx_o = 1; repeat (bt) @(negedge clk_i);
  endtask
  task automatic recv(output logic [7:0] r, input int bt);
    for (int k = 0; k < 30000 && tx_i; k++) @(negedge clk_i);
    repeat (bt / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(negedge clk_i); r[i] = tx_i;
    end
  endtask
endmodule // fps_prog_model
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fps_pkg::*;
  logic clk, rst_n, vpp, sck, si, rx, done, ok, prog, locked, so, oe, hs, tx, req;
  logic [7:0] port_oe, r;
  fps_link_e mode;
  fps_flreq_s cmd;
  fps_cfg_s cfg;
  int failures = 0;
  int check_count = 0;
  fps_top u_fps_top (.MCLK_I(clk), .ARST_N_I(rst_n), .VPP_HI_I(vpp), .SYNC_SERIAL_CLOCK_I(sck),
    .SYNC_SERIAL_IN_I(si), .ASYNC_RX_LINE_I(rx), .FL_DONE_I(done), .FL_OK_I(ok),
    .PROG_MODE_O(prog), .LINK_MODE_O(mode), .LINK_LOCKED_O(locked), .SYNC_SERIAL_OUT_O(so),
    .SYNC_SERIAL_OUT_OE_O(oe), .HANDSHAKE_LINE_O(hs), .ASYNC_TX_LINE_O(tx), .FL_REQ_O(req),
    .FL_CMD_O(cmd), .CFG_O(cfg), .PORT_OE_O(port_oe));
  fps_prog_model u_fps_prog_model (.clk_i(clk), .so_i(so), .tx_i(tx), .rst_n_o(rst_n),
    .vpp_o(vpp), .sck_o(sck), .si_o(si), .rx_o(rx));
  // 40 MHz core clock.
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Flash stand-in answers each request one cycle later.
  always @(posedge clk) done <= req;
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Plain clocked link: answers trail their commands by one byte.
  task automatic t_sync();
    u_fps_prog_model.enter();
    chk(prog, 1'b1);
    chk(port_oe, 8'h00);
    u_fps_prog_model.pulses(0);
    ok = 1;
    u_fps_prog_model.xfer(CMD_ERASE, r);
    chk(r, 8'hff);
    chk(mode, LINK_SYNC);
    chk(oe, 1'b1);
    chk(cmd.op, FL_ERASE);
    ok = 0;
    u_fps_prog_model.xfer(CMD_BLANK, r);
    chk(r, RSP_ACK);
    u_fps_prog_model.xfer(CMD_SIGNATURE, r);
    chk(r, RSP_NAK);
    u_fps_prog_model.xfer(8'h00, r);
    chk(r, RSP_ACK);
    u_fps_prog_model.xfer(8'h00, r);
    chk(r, SIG_CODE);
  endtask
  // Handshake mode with a setting and a write; pulses after the lock change nothing.
  task automatic t_hs();
    logic [47:0] hsw = {CMD_HSWRITE, 24'h012345, 8'h01, 8'h5c};
    u_fps_prog_model.enter();
    u_fps_prog_model.pulses(3);
    u_fps_prog_model.xfer(CMD_RESET, r);
    chk(hs, 1'b1);
    u_fps_prog_model.xfer(CMD_OSC, r);
    chk(r, RSP_ACK);
    u_fps_prog_model.xfer(8'h2a, r);
    chk(cfg.osc, 8'h2a);
    for (int i = 5; i >= 0; i--)
      u_fps_prog_model.xfer(hsw[i*8 +: 8], r);
    chk(cmd, {FL_WRITE, 24'h012345, 8'h5c});
    u_fps_prog_model.pulses(5);
    chk(mode, LINK_SYNC_HS);
  endtask
  // A prohibited count leaves the clocked data out undriven and idle high.
  task automatic t_bad();
    u_fps_prog_model.enter();
    u_fps_prog_model.pulses(5);
    u_fps_prog_model.xfer(CMD_RESET, r);
    chk(r, 8'hff);
    chk(mode, LINK_BAD);
    chk(oe, 1'b0);
  endtask
  // Async at 38400 bps; the answer starts inside the stop bit, so listen from the start.
  task automatic t_async();
    u_fps_prog_model.enter();
    u_fps_prog_model.pulses(8);
    fork
      u_fps_prog_model.send(CMD_RESET, 1042);
      u_fps_prog_model.recv(r, 1042);
    join
    chk(mode, LINK_ASYNC);
    chk(r, RSP_ACK);
  endtask
  initial begin
    ok = 1;
    @(negedge clk);
    t_sync();
    t_hs();
    t_bad();
    t_async();
    results();
  end
  // Watchdog well past the expected run.
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    results();
  end
endmodule // tb_top
`default_nettype wire
